// File: wdc_pkg.sv
// Package for the watchdog control block: register map, field positions, timing.
// Assumes one system clock at 50 MHz; the watchdog count is paced by a tick input.
package wdc_pkg;
   localparam logic [0:0] ADDR_CTRL      = 1'h0;
   localparam logic [0:0] ADDR_CAUSE     = 1'h1;
   localparam int         CTRL_UNLOCK    = 4;
   localparam int         CTRL_ENABLE    = 3;
   localparam int         CAUSE_SCAN     = 4;
   localparam int         CAUSE_DOG      = 3;
   localparam int         CAUSE_BROWN    = 2;
   localparam int         CAUSE_PIN      = 1;
   localparam int         CAUSE_POWER    = 0;
   localparam logic [7:0] CTRL_RESET     = 8'h00;
   localparam logic [7:0] CAUSE_RESET    = 8'h00;
   localparam logic [7:0] CAUSE_LEGACY   = 8'h03;
   localparam logic [2:0] UNLOCK_CYCLES  = 3'h4;
   localparam int         BASE_LOG2      = 14;
   localparam int         CNT_W          = 22;

   typedef enum logic [1:0] {LVL0, LVL1, LVL2} wdc_level_e;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [0:0] addr;
      logic [7:0] wdata;
   } wdc_bus_s;

   typedef struct packed {
      logic power;
      logic pin;
      logic brown;
      logic dog;
      logic scan;
   } wdc_cause_s;
endpackage

// File: wdc_top.sv
// Watchdog control: safety levels, timed unlock, time-out select, reset-cause flags.
// Assumes reset-source pulses and fuse levels are synchronous to CORE_CLK.
`timescale 1ns/100ps
module wdc_top
   import wdc_pkg::*;
#(
   parameter int TICK_DIV = 1
) (
   input  wire logic       CORE_CLK,
   input  wire logic       SRST,
   input  wire logic       WR_STB,
   input  wire logic       RD_STB,
   input  wire logic [0:0] ADDR,
   input  wire logic [7:0] WDATA,
   output logic      [7:0] RDATA,
   input  wire logic       LEGACY_COMPAT_FUSE,
   input  wire logic       DOG_ALWAYS_ON_FUSE,
   input  wire logic       DOG_TICK,
   input  wire logic       DOG_RESTART,
   input  wire logic       RST_POWER,
   input  wire logic       RST_PIN,
   input  wire logic       RST_BROWN,
   input  wire logic       RST_SCAN,
   output logic            DOG_RESET,
   output logic            DOG_RUNNING
);

   wdc_bus_s   bus;
   wdc_cause_s src;
   wdc_level_e level;
   logic       unlock_q;
   logic [2:0] unlock_cnt_q;
   logic       enable_q;
   logic [2:0] sel_q;
   logic [7:0] cause_q;
   logic [CNT_W-1:0] count_q;
   logic       expire;
   logic       ctrl_wr;
   logic       wr_unlock;
   logic       changing;
   logic       run;

   assign bus = '{wr: WR_STB, rd: RD_STB, addr: ADDR, wdata: WDATA};
   assign src = '{power: RST_POWER, pin: RST_PIN, brown: RST_BROWN, dog: expire, scan: RST_SCAN};

   // Fuse decode; the always-on fuse overrides compatibility.
   always_comb begin
      if (DOG_ALWAYS_ON_FUSE) begin
         level = LVL2;
      end else if (LEGACY_COMPAT_FUSE) begin
         level = LVL0;
      end else begin
         level = LVL1;
      end
   end

   assign ctrl_wr   = bus.wr && (bus.addr == ADDR_CTRL);
   // A write with both bits set opens the window even if enable is already one.
   assign wr_unlock = ctrl_wr && bus.wdata[CTRL_UNLOCK] && bus.wdata[CTRL_ENABLE];
   assign changing  = ctrl_wr && !bus.wdata[CTRL_UNLOCK] && unlock_q;

   // Unlock window: consumed by the first change write, else closes after four cycles.
   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         unlock_q     <= 1'b0;
         unlock_cnt_q <= 3'h0;
      end else if (wr_unlock) begin
         unlock_q     <= 1'b1;
         unlock_cnt_q <= 3'h0;
      end else if (changing) begin
         unlock_q     <= 1'b0;
         unlock_cnt_q <= 3'h0;
      end else if (unlock_q) begin
         unlock_cnt_q <= unlock_cnt_q + 3'h1;
         unlock_q     <= (unlock_cnt_q + 3'h1) != UNLOCK_CYCLES;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         enable_q <= 1'b0;
      end else if (ctrl_wr) begin
         if (bus.wdata[CTRL_ENABLE]) begin
            enable_q <= 1'b1;
         end else if (changing && level != LVL2) begin
            enable_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         sel_q <= CTRL_RESET[2:0];
      end else if (ctrl_wr && (level == LVL0 || changing)) begin
         sel_q <= bus.wdata[2:0];
      end
   end

   assign run = enable_q || level == LVL2;

   // Divider tick comes from the watchdog oscillator side; no count beyond the selected length unless sel_q is lowered below the running count.
   assign expire = run && DOG_TICK && (count_q == CNT_W'((32'h1 << (BASE_LOG2 + 32'(sel_q))) - 32'h1));

   always_ff @(posedge CORE_CLK) begin
      if (SRST || !run || DOG_RESTART || expire) begin
         count_q <= '0;
      end else if (DOG_TICK) begin
         count_q <= count_q + CNT_W'(1);
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         DOG_RESET <= 1'b0;
      end else begin
         DOG_RESET <= expire;
      end
   end

   // Cause flags survive SRST; the power-on event clears the others, and a CAUSE write clears the bits written as zero. Set wins over clear.
   always_ff @(posedge CORE_CLK) begin
      logic [7:0] nxt;
      nxt = cause_q;
      if (bus.wr && bus.addr == ADDR_CAUSE) begin
         nxt = cause_q & bus.wdata;
      end
      if (src.power) begin
         nxt = 8'h01;
      end
      nxt[CAUSE_SCAN]  = nxt[CAUSE_SCAN] | src.scan;
      nxt[CAUSE_DOG]   = nxt[CAUSE_DOG] | src.dog;
      nxt[CAUSE_BROWN] = nxt[CAUSE_BROWN] | src.brown;
      nxt[CAUSE_PIN]   = nxt[CAUSE_PIN] | src.pin;
      if (level == LVL0) begin
         nxt = nxt & CAUSE_LEGACY;
      end
      cause_q <= nxt;
   end

   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         RDATA <= 8'h00;
      end else if (bus.rd) begin
         RDATA <= (bus.addr == ADDR_CTRL) ? {3'h0, unlock_q, run, sel_q} : cause_q;
      end else begin
         RDATA <= 8'h00;
      end
   end

   assign DOG_RUNNING = run;

   unlock_close_a : assert property (@(posedge CORE_CLK) disable iff (SRST)
      wr_unlock ##1 (!ctrl_wr)[*4] |=> !unlock_q) else $error("Unlock window not closed.");
   unlock_open_a : assert property (@(posedge CORE_CLK) disable iff (SRST)
      wr_unlock |=> unlock_q) else $error("Unlock window not opened.");
   level2_run_a : assert property (@(posedge CORE_CLK) disable iff (SRST)
      level == LVL2 |-> DOG_RUNNING) else $error("Level 2 watchdog stopped.");
   disable_locked_a : assert property (@(posedge CORE_CLK) disable iff (SRST)
      (enable_q && !unlock_q) |=> enable_q) else $error("Disabled without unlock.");
   sel_locked_a : assert property (@(posedge CORE_CLK) disable iff (SRST)
      (level != LVL0 && !unlock_q) |=> $stable(sel_q)) else $error("Select changed while locked.");
   enable_set_a : assert property (@(posedge CORE_CLK) disable iff (SRST)
      (ctrl_wr && bus.wdata[CTRL_ENABLE]) |=> DOG_RUNNING) else $error("Enable write ignored.");
   pulse_one_a : assert property (@(posedge CORE_CLK) disable iff (SRST)
      DOG_RESET |=> !DOG_RESET) else $error("Reset pulse longer than one cycle.");
   dog_flag_a : assert property (@(posedge CORE_CLK) disable iff (SRST)
      (expire && level != LVL0) |=> cause_q[CAUSE_DOG]) else $error("Watchdog flag not set.");
   // A stopped watchdog must hold a zero count so that re-enabling starts a full period.
   count_clear_a : assert property (@(posedge CORE_CLK) disable iff (SRST)
      (!run || DOG_RESTART) |=> count_q == '0) else $error("Count not cleared.");
   ctrl_rsvd_a : assert property (@(posedge CORE_CLK) disable iff (SRST)
      $past(bus.rd) && $past(bus.addr) == ADDR_CTRL |-> RDATA[7:5] == 3'h0) else $error("Reserved bits nonzero.");
endmodule

// File: wdc_top_test.sv
// Testbench for the watchdog control block: register access, timed unlock, cause flags and expiry.
// Assumes the fuses change only around a reset and that the tick runs every cycle in the expiry part to shorten counts.
`timescale 1ns/100ps
module wdc_top_test;
   import wdc_pkg::*;
   logic       clk  = 1'b0;
   logic       srst = 1'b1;
   logic       wr_s = 1'b0;
   logic       rd_s = 1'b0;
   logic [0:0] addr = 1'h0;
   logic [7:0] wdat = 8'h00;
   logic [7:0] rdat;
   logic       leg  = 1'b0;
   logic       aon  = 1'b0;
   logic       tick = 1'b0;
   logic       rsta = 1'b0;
   logic [3:0] src  = 4'h0;
   logic       dres;
   logic       drun;
   logic [7:0] cexp [4] = '{8'h01, 8'h03, 8'h07, 8'h17};
   int         n_fail   = 0;
   int         n_checks = 0;
   int         t;
   always #10 clk = ~clk;
   wdc_top dut (.CORE_CLK(clk), .SRST(srst), .WR_STB(wr_s), .RD_STB(rd_s), .ADDR(addr), .WDATA(wdat),
      .RDATA(rdat), .LEGACY_COMPAT_FUSE(leg), .DOG_ALWAYS_ON_FUSE(aon), .DOG_TICK(tick),
      .DOG_RESTART(rsta), .RST_POWER(src[0]), .RST_PIN(src[1]), .RST_BROWN(src[2]), .RST_SCAN(src[3]),
      .DOG_RESET(dres), .DOG_RUNNING(drun));
   task end_sim;
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input string n, input logic [7:0] e, input logic [7:0] s);
      n_checks++;
      if (s !== e) begin
         $display("BAD %s expected %h seen %h", n, e, s);
         n_fail++;
      end
   endtask
   task wr(input logic [0:0] a, input logic [7:0] d);
      @(posedge clk);
      wr_s <= 1'b1;
      addr <= a;
      wdat <= d;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask
   // The strobe is taken at the next edge and the data stand only in the cycle after that edge.
   task rd(input logic [0:0] a, input logic [7:0] e, input string n);
      @(posedge clk);
      rd_s <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 chk(n, e, rdat);
   endtask
   task pulse(input int i);
      @(posedge clk);
      src <= 4'h1 << i;
      @(posedge clk);
      src <= 4'h0;
   endtask
   task do_reset;
      @(posedge clk);
      srst <= 1'b1;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      rd(ADDR_CTRL, CTRL_RESET, "ctrl reset");
      for (int i = 0; i < 4; i++) begin
         pulse(i);
         rd(ADDR_CAUSE, cexp[i], "cause set");
      end
      pulse(0);
      rd(ADDR_CAUSE, 8'h01, "power clears others");
      wr(ADDR_CAUSE, 8'h00);
      rd(ADDR_CAUSE, 8'h00, "cause clear");
      wr(ADDR_CTRL, 8'h08);
      rd(ADDR_CTRL, 8'h08, "enable free");
      wr(ADDR_CTRL, 8'hE7);
      rd(ADDR_CTRL, 8'h08, "locked change");
      wr(ADDR_CTRL, 8'h18);
      rd(ADDR_CTRL, 8'h18, "unlock set");
      repeat (4) @(posedge clk);
      rd(ADDR_CTRL, 8'h08, "unlock self clear");
      wr(ADDR_CTRL, 8'h00);
      rd(ADDR_CTRL, 8'h08, "late change");
      wr(ADDR_CTRL, 8'h18);
      wr(ADDR_CTRL, 8'h05);
      rd(ADDR_CTRL, 8'h05, "unlocked change");
      chk("running off", 8'h00, {7'h00, drun});
      wr(ADDR_CTRL, 8'h0E);
      rd(ADDR_CTRL, 8'h0D, "window closed");
      leg <= 1'b1;
      do_reset();
      wr(ADDR_CTRL, 8'h0B);
      wr(ADDR_CTRL, 8'h0C);
      rd(ADDR_CTRL, 8'h0C, "level0 select");
      pulse(2);
      rd(ADDR_CAUSE, 8'h00, "legacy brown");
      pulse(1);
      rd(ADDR_CAUSE, 8'h02, "legacy pin");
      leg <= 1'b0;
      aon <= 1'b1;
      do_reset();
      rd(ADDR_CTRL, 8'h08, "level2 enable");
      wr(ADDR_CTRL, 8'h18);
      wr(ADDR_CTRL, 8'h02);
      rd(ADDR_CTRL, 8'h0A, "level2 change");
      chk("running on", 8'h01, {7'h00, drun});
      aon <= 1'b0;
      do_reset();
      wr(ADDR_CAUSE, 8'h00);
      wr(ADDR_CTRL, 8'h08);
      tick <= 1'b1;
      repeat (10000) @(posedge clk);
      rsta <= 1'b1;
      @(posedge clk);
      rsta <= 1'b0;
      // Ticks every cycle, so the shortest time-out is counted in system cycles after the restart.
      t = 0;
      while (dres !== 1'b1 && t < 17000) begin
         @(posedge clk);
         #1 t++;
      end
      if (t == 17000) begin
         $display("BAD expiry wait expected 1 seen 0");
         n_fail++;
      end else begin
         chk("expiry time", 8'h01, {7'h00, t == 16384});
         @(posedge clk);
         #1 chk("pulse width", 8'h00, {7'h00, dres});
         tick <= 1'b0;
         rd(ADDR_CAUSE, 8'h08, "dog flag");
      end
      end_sim();
   end
endmodule
